/* sdr_addr_gen.sv */
// serial address register and block/word address counter
// assumes strobes are single-cycle pulses from the control core
`timescale 1ns/1ps
module sdr_addr_gen (
	input wire logic clk_sys,
	input wire logic reset_n,
	sdr_if.gen       bus
);
	typedef struct packed {
		logic [9:0] shift;
		logic [9:0] x;
		logic [9:0] y;
	} sdr_gen_st_t;

	sdr_gen_st_t s_reg;
	sdr_gen_st_t s_next;

	always_comb begin
		s_next = s_reg;
		if (bus.shiftStb) begin
			// first bit in ends up in bit 0 after ten strobes
			s_next.shift = {bus.shiftBit, s_reg.shift[9:1]};
		end
		if (bus.loadStb) begin
			s_next.x = s_reg.shift;
			s_next.y = sdr_pkg::SEG_RST;
		end else if (bus.incStb) begin
			if (s_reg.y == sdr_pkg::SEG_LAST) begin
				s_next.y = sdr_pkg::SEG_RST;
				// fast cycles stay inside the block
				if (!bus.fastMode) begin
					s_next.x = s_reg.x + 10'h001;
				end
			end else begin
				s_next.y = s_reg.y + 10'h001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_reg <= '{sdr_pkg::SHIFT_RST, sdr_pkg::SEG_RST, sdr_pkg::SEG_RST};
		end else begin
			s_reg <= s_next;
		end
	end

	assign bus.addr     = {s_reg.x, s_reg.y};
	assign bus.shiftReg = s_reg.shift;
endmodule : sdr_addr_gen

/* sdr_host.sv */
// host model: drives address, access, select and refresh pins
// assumes one clk_sys domain; pins change just after rising edges
`timescale 1ns/1ps
module sdr_host (
	input  wire logic clk_sys,
	input  wire logic dataOut,
	input  wire logic dataOutEn,
	output logic      serialAddrData,
	output logic      serialAddrStrobe,
	output logic      addrTransferStrobe_n,
	output logic      accessClock_n,
	output logic      writeEnable_n,
	output logic      dataIn,
	output logic      chipSelect_n,
	output logic      refreshSelect_n,
	output logic      refreshPulse_n,
	output logic      fastModeSelect_n
);
	logic readBit;
	logic readEn;

	// ------
	// idle levels
	// ------
	// no test pin on the model; the board ties it high
	initial begin
		serialAddrData       = 1'b0;
		serialAddrStrobe     = 1'b0;
		addrTransferStrobe_n = 1'b1;
		accessClock_n        = 1'b1;
		writeEnable_n        = 1'b1;
		dataIn               = 1'b0;
		chipSelect_n         = 1'b0;
		refreshSelect_n      = 1'b1;
		refreshPulse_n       = 1'b1;
		fastModeSelect_n     = 1'b1;
	end

	// ------
	// pin tasks
	// ------
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task automatic load_addr(input logic [9:0] blk);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			serialAddrStrobe <= 1'b0;
			serialAddrData   <= blk[i];
			@(posedge clk_sys);
			serialAddrStrobe <= 1'b1;
		end
		@(posedge clk_sys);
		serialAddrStrobe <= 1'b0;
		// spare cycle so the last shift lands before the transfer
		@(posedge clk_sys);
		addrTransferStrobe_n <= 1'b0;
		@(posedge clk_sys);
		addrTransferStrobe_n <= 1'b1;
		serialAddrData       <= ~blk[9];
		step(3);
	endtask : load_addr

	task automatic access(input sdr_pkg::sdr_acc_t m, input logic d,
		input logic fn, input int lc);
		@(posedge clk_sys);
		accessClock_n <= 1'b0;
		writeEnable_n <= (m != sdr_pkg::ACC_WRITE);
		dataIn        <= d;
		@(posedge clk_sys);
		// level moves only with the clock low
		fastModeSelect_n <= fn;
		if (m == sdr_pkg::ACC_RMW)
			writeEnable_n <= 1'b0;
		step(lc);
		readBit = dataOut;
		readEn  = dataOutEn;
		@(posedge clk_sys);
		accessClock_n <= 1'b1;
		writeEnable_n <= 1'b1;
		// stale data would hide a late capture
		dataIn        <= ~d;
	endtask : access

	// pulses only between accesses, clock high
	task automatic refresh(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			refreshPulse_n <= 1'b0;
			@(posedge clk_sys);
			refreshPulse_n <= 1'b1;
		end
		step(2);
	endtask : refresh

	task automatic select(input logic cs, input logic rs);
		@(posedge clk_sys);
		chipSelect_n    <= cs;
		refreshSelect_n <= rs;
		step(2);
	endtask : select
endmodule : sdr_host

/* sdr_if.sv */
// carrier between the control core, address generator and bit store
// assumes one clock domain, clk_sys
`timescale 1ns/1ps
interface sdr_if;
	logic        shiftStb;
	logic        shiftBit;
	logic        loadStb;
	logic        incStb;
	logic        fastMode;
	logic [19:0] addr;
	logic [9:0]  shiftReg;
	logic        memWe;
	logic        memWdata;
	logic [19:0] memAddr;
	logic        memRdata;

	modport ctl (output shiftStb, shiftBit, loadStb, incStb, fastMode,
		memWe, memWdata, memAddr, input addr, shiftReg, memRdata);
	modport gen (input shiftStb, shiftBit, loadStb, incStb, fastMode,
		output addr, shiftReg);
	modport mem (input memWe, memWdata, memAddr, output memRdata);
endinterface : sdr_if

/* sdr_pkg.sv */
// shared constants, state codes and edge helpers of the serial data register
// assumes all pins are synchronous to clk_sys at 40 MHz
package sdr_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int          SEG_W      = 10;
	localparam int          ADDR_W     = 20;
	localparam int          MEM_DEPTH  = 1048576;
	localparam logic [9:0]  SEG_LAST   = 10'h3FF;
	localparam logic [9:0]  SHIFT_RST  = 10'h000;
	localparam logic [9:0]  SEG_RST    = 10'h000;
	localparam logic [19:0] ADDR_RST   = 20'h00000;
	localparam logic [19:0] ADDR_STEP  = 20'h00001;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int          CLK_HZ        = 40000000;
	localparam int          REF_PERIOD_MS = 100;
	localparam int          REF_ROWS      = 1024;
	// longest spacing per row, rounded down
	localparam int          SELF_TICK_CYC =
		(CLK_HZ / 1000 * REF_PERIOD_MS) / REF_ROWS;
	localparam logic [11:0] SELF_TICK_LAST = 12'(SELF_TICK_CYC - 1);
	localparam logic [11:0] TIMER_RST      = 12'h000;
	localparam logic [3:0]  PWR_CYCLES     = 4'h8;
	localparam logic [3:0]  PWR_RST        = 4'h0;

	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_READ  = 2'b01,
		ACC_WRITE = 2'b10,
		ACC_RMW   = 2'b11
	} sdr_acc_t;

	function automatic logic fell(input logic prev, input logic now);
		fell = prev & ~now;
	endfunction : fell

	function automatic logic rose(input logic prev, input logic now);
		rose = ~prev & now;
	endfunction : rose

endpackage : sdr_pkg

/* sdr_store.sv */
// one-bit-wide cell array with registered read
// assumes address is stable in the cycle a write strobe is given
`timescale 1ns/1ps
module sdr_store (
	input wire logic clk_sys,
	sdr_if.mem       bus
);
	logic mem [0:sdr_pkg::MEM_DEPTH-1];
	logic rdReg;

	// cells hold no reset; contents are undefined until written
	always_ff @(posedge clk_sys) begin
		if (bus.memWe) begin
			mem[bus.memAddr] <= bus.memWdata;
		end
		rdReg <= mem[bus.memAddr];
	end

	assign bus.memRdata = rdReg;
endmodule : sdr_store

/* sdr_tb_top.sv */
// self-checking bench: random and corner accesses against a bit model
// assumes sdr_top and sdr_host share clk_sys
`timescale 1ns/1ps
module sdr_tb_top;
	// ------
	// wiring
	// ------
	logic        clk_sys;
	logic        reset_n;
	wire         serialAddrData, serialAddrStrobe, addrTransferStrobe_n;
	wire         accessClock_n, writeEnable_n, dataIn, chipSelect_n;
	wire         refreshSelect_n, refreshPulse_n, fastModeSelect_n;
	wire         dataOut, dataOutEn, selfRefreshOn, powerUpDone;
	wire [9:0]   refreshRow;
	wire [19:0]  addrCounter;
	int          num_errors;
	int          check_count;
	int          cycles = 0;
	int          n;
	logic        memModel [int];
	logic [19:0] addrModel;
	logic [19:0] saved;
	logic [9:0]  blk;
	logic [9:0]  row0;
	logic        fastLevel;

	sdr_top dut (.clk_sys, .reset_n, .serialAddrData, .serialAddrStrobe,
		.addrTransferStrobe_n, .accessClock_n, .writeEnable_n, .dataIn,
		.chipSelect_n, .refreshSelect_n, .refreshPulse_n,
		.fastModeSelect_n, .dataOut, .dataOutEn, .refreshRow,
		.selfRefreshOn, .powerUpDone, .addrCounter);
	sdr_host host (.clk_sys, .dataOut, .dataOutEn, .serialAddrData,
		.serialAddrStrobe, .addrTransferStrobe_n, .accessClock_n,
		.writeEnable_n, .dataIn, .chipSelect_n, .refreshSelect_n,
		.refreshPulse_n, .fastModeSelect_n);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ------
	// model and checks
	// ------
	function automatic logic [19:0] next_addr(input logic [19:0] a,
		input logic f);
		next_addr = f ? a + 20'h00001 : {a[19:10], a[9:0] + 10'h001};
	endfunction : next_addr

	task automatic check(input string what, input logic [19:0] seen,
		input logic [19:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic load(input logic [9:0] b);
		host.load_addr(b);
		addrModel = {b, 10'h000};
		check("loaded address", addrCounter, addrModel);
	endtask : load

	task automatic acc(input sdr_pkg::sdr_acc_t m, input logic d,
		input logic fn, input int lc);
		logic e;
		e = memModel.exists(int'(addrModel)) ?
			memModel[int'(addrModel)] : 1'bx;
		host.access(m, d, fn, lc);
		if (m != sdr_pkg::ACC_WRITE && lc > 2) begin
			check("read data", host.readBit, e);
			check("read enable", host.readEn, 1'b1);
		end
		if (m == sdr_pkg::ACC_WRITE && lc > 2)
			check("write enable", host.readEn, 1'b0);
		if (m != sdr_pkg::ACC_READ)
			memModel[int'(addrModel)] = d;
		addrModel = next_addr(addrModel, fastLevel);
		fastLevel = fn;
	endtask : acc

	task final_report;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			num_errors = num_errors + 1;
			final_report;
		end
	end

	// ------
	// tests
	// ------
	initial begin
		reset_n     = 1'b0;
		num_errors  = 0;
		check_count = 0;
		fastLevel   = 1'b1;
		void'($urandom(32'hC6CD));
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		host.step(1);
		check("reset address", addrCounter, 20'h00000);
		check("reset enable", dataOutEn, 1'b0);
		// settle time before first use, over 100 us of clk_sys
		host.step(4001);
		$display("test reset done");
		blk = 10'($urandom);
		load(blk);
		for (int i = 0; i < 12; i++) begin
			acc(sdr_pkg::ACC_WRITE, 1'($urandom), 1'b1, 3);
			if (i == 6)
				check("power-up early", powerUpDone, 1'b0);
			if (i == 7)
				check("power-up done", powerUpDone, 1'b1);
		end
		check("advanced address", addrCounter, addrModel);
		$display("test write burst done");
		load(blk);
		for (int i = 0; i < 12; i++)
			acc(sdr_pkg::ACC_READ, 1'($urandom), 1'b1, 3 + i % 2);
		host.step(2);
		check("released output", dataOutEn, 1'b0);
		$display("test read burst done");
		load(blk);
		acc(sdr_pkg::ACC_RMW, ~memModel[int'(addrModel)], 1'b1, 3);
		load(blk);
		acc(sdr_pkg::ACC_READ, 1'b0, 1'b1, 3);
		$display("test modify done");
		load(10'($urandom));
		for (int i = 0; i < 1025; i++)
			acc(sdr_pkg::ACC_WRITE, 1'($urandom), 1'b0, 0);
		host.step(2);
		check("fast wrap", addrCounter, addrModel);
		for (int i = 0; i < 1023; i++)
			acc(sdr_pkg::ACC_WRITE, 1'($urandom), 1'b1, 0);
		host.step(2);
		check("block carry", addrCounter, addrModel);
		$display("test wrap done");
		host.select(1'b1, 1'b1);
		saved = addrCounter;
		host.load_addr(~blk);
		host.access(sdr_pkg::ACC_READ, 1'b0, 1'b1, 3);
		check("deselected enable", host.readEn, 1'b0);
		check("deselected address", addrCounter, saved);
		host.select(1'b0, 1'b1);
		$display("test select done");
		row0 = refreshRow;
		n    = $urandom_range(9, 3);
		host.refresh(n);
		check("external rows", refreshRow, row0 + 10'(n));
		check("external mode", selfRefreshOn, 1'b0);
		host.select(1'b0, 1'b0);
		check("self mode", selfRefreshOn, 1'b1);
		row0 = refreshRow;
		host.step(sdr_pkg::SELF_TICK_CYC);
		check("self tick", refreshRow, row0 + 10'h001);
		$display("test refresh done");
		final_report;
	end
endmodule : sdr_tb_top

/* sdr_top.sv */
// serial-access 1M x 1 data register, pin-level behaviour
// assumes all pins synchronous to clk_sys; no reset pin on the device,
// reset_n stands for power-on
//
// Behaviour
// - start address is ten serial bits
// - each address strobe shifts one bit in
// - transfer strobe loads shift register into counter
// - transfer strobe fall clears word part
// - access clock fall starts read or write
// - address counter advances on each access fall
// - write enable high reads, low writes
// - write enable fall mid-cycle gives read-modify-write
// - write data taken on clock or enable fall
// - output released while clock or select high
// - read data held until clock rises
// - early write keeps output released
// - refresh select low self, high external
// - fast cycles while fast select held low
// - select high ignores inputs except access clock rise and refresh select, releases output
`timescale 1ns/1ps
module sdr_top (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        serialAddrData,
	input  wire logic        serialAddrStrobe,
	input  wire logic        addrTransferStrobe_n,
	input  wire logic        accessClock_n,
	input  wire logic        writeEnable_n,
	input  wire logic        dataIn,
	input  wire logic        chipSelect_n,
	input  wire logic        refreshSelect_n,
	input  wire logic        refreshPulse_n,
	input  wire logic        fastModeSelect_n,
	output      logic        dataOut,
	output      logic        dataOutEn,
	output      logic [9:0]  refreshRow,
	output      logic        selfRefreshOn,
	output      logic        powerUpDone,
	output      logic [19:0] addrCounter
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                strbPrev;
		logic                xferPrev;
		logic                accPrev;
		logic                we;
		logic                refPrev;
		sdr_pkg::sdr_acc_t   acc;
		logic [19:0]         cycAddr;
		logic                dout;
		logic                doutEn;
		logic                readPend;
		logic [9:0]          refRow;
		logic [11:0]         selfTimer;
		logic                selfOn;
		logic [3:0]          pwrCnt;
		logic                pwrDone;
		logic [19:0]         addrShow;
	} sdr_top_st_t;

	sdr_top_st_t s_reg;
	sdr_top_st_t s_next;
	sdr_if       bus ();

	logic selOn;
	logic strbRise;
	logic xferFall;
	logic accFall;
	logic accRise;
	logic weFall;
	logic refFall;

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	sdr_addr_gen u_gen (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.bus     (bus.gen)
	);

	sdr_store u_store (
		.clk_sys (clk_sys),
		.bus     (bus.mem)
	);

	// ------------------------------------------------------------
	// pin events
	// ------------------------------------------------------------
	// deselected device sees no edges except the access clock rise
	assign selOn    = ~chipSelect_n;
	assign strbRise = selOn &
		sdr_pkg::rose(s_reg.strbPrev, serialAddrStrobe);
	assign xferFall = selOn &
		sdr_pkg::fell(s_reg.xferPrev, addrTransferStrobe_n);
	assign accFall  = selOn & sdr_pkg::fell(s_reg.accPrev, accessClock_n);
	assign accRise  = sdr_pkg::rose(s_reg.accPrev, accessClock_n);
	assign weFall   = selOn & sdr_pkg::fell(s_reg.we, writeEnable_n);
	assign refFall  = selOn &
		sdr_pkg::fell(s_reg.refPrev, refreshPulse_n);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_next      = s_reg;
		s_next.strbPrev = serialAddrStrobe;
		s_next.xferPrev = addrTransferStrobe_n;
		s_next.accPrev  = accessClock_n;
		s_next.we       = writeEnable_n;
		s_next.refPrev  = refreshPulse_n;
		s_next.addrShow = bus.addr;

		bus.shiftStb = strbRise;
		bus.shiftBit = serialAddrData;
		bus.loadStb  = xferFall;
		bus.incStb   = accFall;
		bus.fastMode = ~fastModeSelect_n;
		bus.memWe    = 1'b0;
		bus.memWdata = dataIn;
		bus.memAddr  = bus.addr;

		// access cycle
		if (accFall) begin
			s_next.cycAddr = bus.addr;
			if (writeEnable_n) begin
				s_next.acc      = sdr_pkg::ACC_READ;
				s_next.readPend = 1'b1;
			end else begin
				// early write: cell updated at clock fall
				s_next.acc = sdr_pkg::ACC_WRITE;
				bus.memWe  = 1'b1;
			end
		end else if (weFall && !accessClock_n &&
				s_reg.acc == sdr_pkg::ACC_READ) begin
			// late write lands on the address read in this cycle
			s_next.acc   = sdr_pkg::ACC_RMW;
			bus.memWe    = 1'b1;
			bus.memAddr  = s_reg.cycAddr;
		end else if (accRise) begin
			s_next.acc = sdr_pkg::ACC_IDLE;
		end

		// read data lands two cycles after the fall (registered array)
		if (s_reg.readPend) begin
			s_next.readPend = 1'b0;
			s_next.dout     = bus.memRdata;
			s_next.doutEn   = 1'b1;
		end
		// release wins over any pending drive; early write never drives
		if (accessClock_n || chipSelect_n) begin
			s_next.doutEn = 1'b0;
		end

		// refresh bookkeeping
		s_next.selfOn = ~refreshSelect_n;
		if (s_reg.selfOn) begin
			if (s_reg.selfTimer == sdr_pkg::SELF_TICK_LAST) begin
				s_next.selfTimer = sdr_pkg::TIMER_RST;
				s_next.refRow    = s_reg.refRow + 10'h001;
			end else begin
				s_next.selfTimer = s_reg.selfTimer + 12'h001;
			end
		end else begin
			s_next.selfTimer = sdr_pkg::TIMER_RST;
			// external pulses only count with the access clock idle
			if (refFall && accessClock_n) begin
				s_next.refRow = s_reg.refRow + 10'h001;
			end
		end

		// warm-up: status only, accesses are not blocked
		if (accFall && !s_reg.pwrDone) begin
			s_next.pwrCnt = s_reg.pwrCnt + 4'h1;
			if (s_reg.pwrCnt == sdr_pkg::PWR_CYCLES - 4'h1) begin
				s_next.pwrDone = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s_reg.strbPrev  <= 1'b0;
			s_reg.xferPrev  <= 1'b1;
			s_reg.accPrev   <= 1'b1;
			s_reg.we        <= 1'b1;
			s_reg.refPrev   <= 1'b1;
			s_reg.acc       <= sdr_pkg::ACC_IDLE;
			s_reg.cycAddr   <= sdr_pkg::ADDR_RST;
			s_reg.dout      <= 1'b0;
			s_reg.doutEn    <= 1'b0;
			s_reg.readPend  <= 1'b0;
			s_reg.refRow    <= sdr_pkg::SEG_RST;
			s_reg.selfTimer <= sdr_pkg::TIMER_RST;
			s_reg.selfOn    <= 1'b0;
			s_reg.pwrCnt    <= sdr_pkg::PWR_RST;
			s_reg.pwrDone   <= 1'b0;
			s_reg.addrShow  <= sdr_pkg::ADDR_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign dataOut       = s_reg.dout;
	assign dataOutEn     = s_reg.doutEn;
	assign refreshRow    = s_reg.refRow;
	assign selfRefreshOn = s_reg.selfOn;
	assign powerUpDone   = s_reg.pwrDone;
	assign addrCounter   = s_reg.addrShow;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	out_release_a: assert property (
		(accessClock_n || chipSelect_n) |=> !dataOutEn)
		else $error("output driven with clock or select high");

	shift_in_a: assert property (
		strbRise |=> bus.shiftReg[9] == $past(serialAddrData) &&
			bus.shiftReg[8:0] == $past(bus.shiftReg[9:1]))
		else $error("serial address bit not shifted in");

	shift_hold_a: assert property (
		!strbRise |=> $stable(bus.shiftReg))
		else $error("shift register moved without strobe");

	load_clear_a: assert property (
		xferFall |=> bus.addr[9:0] == 10'h000 &&
			bus.addr[19:10] == $past(bus.shiftReg))
		else $error("transfer strobe did not load and clear");

	inc_carry_a: assert property (
		(accFall && !xferFall && fastModeSelect_n)
			|=> bus.addr == $past(bus.addr) + sdr_pkg::ADDR_STEP)
		else $error("normal access did not advance address");

	fast_hold_a: assert property (
		(accFall && !xferFall && !fastModeSelect_n)
			|=> bus.addr[19:10] == $past(bus.addr[19:10]))
		else $error("fast access changed block address");

	read_drive_a: assert property (
		(accFall && writeEnable_n ##1 (!accessClock_n && selOn))
			|=> dataOutEn && dataOut == $past(bus.memRdata))
		else $error("read data not driven after clock fall");

	read_hold_a: assert property (
		(dataOutEn && !accessClock_n && !chipSelect_n)
			|=> dataOutEn && $stable(dataOut))
		else $error("read data not held while clock low");

	early_write_a: assert property (
		(accFall && !writeEnable_n) |-> bus.memWe &&
			bus.memWdata == dataIn && bus.memAddr == bus.addr
			##1 s_reg.acc == sdr_pkg::ACC_WRITE)
		else $error("early write not stored at clock fall");

	write_quiet_a: assert property (
		(s_reg.acc == sdr_pkg::ACC_WRITE) |-> !dataOutEn)
		else $error("output driven in early write");

	rmw_entry_a: assert property (
		(weFall && !accessClock_n && !accFall &&
			s_reg.acc == sdr_pkg::ACC_READ)
			|-> bus.memWe && bus.memAddr == s_reg.cycAddr
			##1 s_reg.acc == sdr_pkg::ACC_RMW)
		else $error("read-modify-write not entered");

	desel_hold_a: assert property (
		chipSelect_n |=> $stable(bus.addr) && $stable(bus.shiftReg))
		else $error("deselected device changed address state");

	mode_pick_a: assert property (
		(accFall && writeEnable_n) |=> s_reg.acc == sdr_pkg::ACC_READ)
		else $error("read mode not selected with enable high");

	ref_mode_a: assert property (
		refreshSelect_n [*2] |-> !selfRefreshOn)
		else $error("self refresh on with select high");

	ext_refresh_a: assert property (
		(!s_reg.selfOn && refFall && accessClock_n)
			|=> refreshRow == $past(refreshRow) + 10'h001)
		else $error("external refresh pulse not counted");

	self_tick_a: assert property (
		(s_reg.selfOn && s_reg.selfTimer == sdr_pkg::SELF_TICK_LAST)
			|=> refreshRow == $past(refreshRow) + 10'h001)
		else $error("self refresh tick not counted");

	pwr_done_a: assert property (
		(accFall && s_reg.pwrCnt == sdr_pkg::PWR_CYCLES - 4'h1)
			|=> powerUpDone)
		else $error("power-up not flagged after eight cycles");

endmodule : sdr_top
